// file: rtc3_top.sv
/*
  rtc3_top: battery control and seconds/minutes/hours timekeeping with an
  APB slave, a sticky interrupt status/mask pair and one interrupt line.
  Assumes async pin inputs for switchover, battery low and oscillator
  failure, a 50 MHz pclk, and an APB master that holds its request.
  Written time values are not range-checked: an illegal BCD code steps
  on from where it stands, as a trade for a smaller write path.
*/
`timescale 1ns/1ps
module rtc3_top
  import rtc3_pkg::*;
#(
  parameter int TICK_CYCLES = rtc3_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // battery and oscillator monitors (asynchronous)
  input wire logic switchover_in,
  input wire logic battery_low_in,
  input wire logic osc_fail_in,
  // interrupt
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    // pin synchronisers and edge history
    logic sw_meta;
    logic sw_sync;
    logic sw_prev;
    logic low_meta;
    logic low_sync;
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    // software controls and sticky flags
    logic fmt12;
    logic [2:0] battery_power_mode;
    logic switchover_flag;
    logic switchover_irq_enable;
    logic low_battery_irq_enable;
    logic oscillator_stopped_flag;
    // time counters, all BCD
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hrs;
    // interrupt status and mask
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    // registered bus answer and interrupt line
    logic [7:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } rtc3_state_s;

  // reset image; the oscillator flag starts set so software can tell
  // that the time has not been written since power-up
  localparam rtc3_state_s ST_RESET = '{
    sw_meta: 1'b0, sw_sync: 1'b0, sw_prev: 1'b0,
    low_meta: 1'b0, low_sync: 1'b0,
    osc_meta: 1'b0, osc_sync: 1'b0, osc_prev: 1'b0,
    fmt12: 1'b0,
    battery_power_mode: BATT_MODE_RESET,
    switchover_flag: 1'b0,
    switchover_irq_enable: 1'b0,
    low_battery_irq_enable: 1'b0,
    oscillator_stopped_flag: 1'b1,
    sec: SEC_RESET, min: MIN_RESET, hrs: HRS_RESET,
    irq_stat: 3'h0, irq_mask: IRQ_MASK_RESET,
    rdata: 8'h00, ready: 1'b0, err: 1'b0, irq: 1'b0
  };

  rtc3_state_s q, d;

  // ==========================================================
  // decode helpers

  // word index from a byte address
  // paddr[1:0] is ignored: every register is one aligned word
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  // true for any address that holds a register
  // an address outside the map gives an error and changes nothing
  function automatic logic addr_hit(input logic [11:0] addr);
    logic [7:0] i;
    i = reg_index(addr);
    addr_hit = (addr[11:10] == 2'h0) && (i == IDX_HOUR_FMT || i == IDX_BATT
      || i == IDX_SEC || i == IDX_MIN || i == IDX_HRS
      || i == IDX_IRQ_STAT || i == IDX_IRQ_MASK);
  endfunction

  // hour step in either layout; 12 hour toggles PM going 11 to 12
  function automatic logic [5:0] hour_step(input logic [5:0] h, input logic f12);
    logic pm;
    logic [4:0] hr;
    pm = h[HRS_PM_BIT];
    hr = h[4:0];
    hour_step = h;
    // no range check: codes above the top value wrap to the first hour
    if (f12) begin
      if (hr >= 5'h12) begin
        hour_step = {pm, 5'h01};
      end else if (hr == 5'h11) begin
        hour_step = {~pm, 5'h12};
      end else if (hr[3:0] >= 4'h9) begin
        hour_step = {pm, 5'h10};
      end else begin
        hour_step = {pm, hr[4], hr[3:0] + 4'h1};
      end
    end else begin
      if (h >= 6'h23) begin
        hour_step = 6'h00;
      end else if (h[3:0] >= 4'h9) begin
        hour_step = {h[5:4] + 2'h1, 4'h0};
      end else begin
        hour_step = {h[5:4], h[3:0] + 4'h1};
      end
    end
  endfunction

  // ==========================================================
  // one-second tick and BCD steps for seconds and minutes
  logic tick;
  logic sec_write;
  logic [7:0] unit_cur [2];
  logic [7:0] unit_nxt [2];
  logic unit_wrap [2];

  // the period is a parameter so a bench can shorten the second;
  // a minutes or hours write does not restart it and can land just before a tick
  // seconds write restarts the second so the new value lasts a full second
  rtc3_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(sec_write),
    .period(TICK_W'(TICK_CYCLES)),
    .tick(tick)
  );

  assign unit_cur[0] = {1'b0, q.sec};
  assign unit_cur[1] = {1'b0, q.min};

  // seconds and minutes share one BCD stepper design, one per unit
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_unit
      rtc3_bcd_inc u_inc (
        .cur(unit_cur[g]),
        .top_val(BCD_59),
        .low_val(BCD_00),
        .nxt(unit_nxt[g]),
        .wrap(unit_wrap[g])
      );
    end
  endgenerate

  // ==========================================================
  // bus phases
  logic setup_ph;
  logic acc_ph;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [7:0] wbyte;

  // access is qualified by our own ready, so a master that lingers in
  // the access phase can never write a register twice
  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable & q.ready;
  assign wr_en = acc_ph & pwrite & pstrb[0] & ~q.err;
  assign rd_en = acc_ph & ~pwrite & ~q.err;
  assign idx = reg_index(paddr);
  assign wbyte = pwdata[7:0];
  assign sec_write = wr_en & (idx == IDX_SEC);

  // ==========================================================
  // next state
  logic sw_rise;
  logic osc_rise;
  logic [2:0] irq_set;

  always_comb begin
    d = q;

    // two-stage synchronisers; only the second stage feeds logic
    // the extra stage on switchover and oscillator gives the edge history
    d.sw_meta = switchover_in;
    d.sw_sync = q.sw_meta;
    d.sw_prev = q.sw_sync;
    d.low_meta = battery_low_in;
    d.low_sync = q.low_meta;
    d.osc_meta = osc_fail_in;
    d.osc_sync = q.osc_meta;
    d.osc_prev = q.osc_sync;
    sw_rise = q.sw_sync & ~q.sw_prev;
    osc_rise = q.osc_sync & ~q.osc_prev;

    // timekeeping: seconds carry into minutes, minutes into hours
    // a carry only moves when the lower unit wraps on this very tick
    if (tick) begin
      d.sec = unit_nxt[0][6:0];
      if (unit_wrap[0]) begin
        d.min = unit_nxt[1][6:0];
        if (unit_wrap[1]) begin
          d.hrs = hour_step(q.hrs, q.fmt12);
        end
      end
    end

    // register writes; a write wins over the count in the same cycle
    // a write to a read-only bit or to the status register is ignored
    if (wr_en) begin
      case (idx)
        IDX_HOUR_FMT: begin
          d.fmt12 = wbyte[FMT_12H_BIT];
        end
        IDX_BATT: begin
          d.battery_power_mode = wbyte[7:BATT_MODE_LSB];
          d.switchover_irq_enable = wbyte[BATT_SWIE_BIT];
          d.low_battery_irq_enable = wbyte[BATT_LOWIE_BIT];
          // writing one to the flag has no effect; only hardware sets it
          if (!wbyte[BATT_SWITCH_BIT]) begin
            d.switchover_flag = 1'b0;
          end
        end
        IDX_SEC: begin
          d.sec = wbyte[6:0];
          d.oscillator_stopped_flag = wbyte[SEC_OSC_BIT];
        end
        IDX_MIN: begin
          d.min = wbyte[6:0];
        end
        IDX_HRS: begin
          d.hrs = wbyte[5:0];
        end
        IDX_IRQ_MASK: begin
          d.irq_mask = wbyte[2:0];
        end
        default: begin
        end
      endcase
    end

    // hardware sets win over software clears in the same cycle
    // so an event is never lost to a clear that software issued blindly
    if (sw_rise) begin
      d.switchover_flag = 1'b1;
    end
    if (osc_rise) begin
      d.oscillator_stopped_flag = 1'b1;
    end

    // sticky status, cleared by a read of the status register
    // a read clears every status bit, also one set after the setup sample; an event on that edge stays
    irq_set = 3'h0;
    irq_set[IRQ_SECOND_BIT] = tick;
    irq_set[IRQ_MINUTE_BIT] = tick & unit_wrap[0];
    irq_set[IRQ_OSC_BIT] = osc_rise;
    if (rd_en && idx == IDX_IRQ_STAT) begin
      d.irq_stat = irq_set;
    end else begin
      d.irq_stat = q.irq_stat | irq_set;
    end

    // read data is latched in setup so it stands through the access phase
    // and drops to zero after it, so idle read data never goes stale
    d.ready = setup_ph;
    d.err = setup_ph & ~addr_hit(paddr);
    d.rdata = 8'h00;
    if (setup_ph) begin
      case (idx)
        IDX_HOUR_FMT: begin
          d.rdata[FMT_12H_BIT] = q.fmt12;
        end
        IDX_BATT: begin
          d.rdata[7:BATT_MODE_LSB] = q.battery_power_mode;
          d.rdata[BATT_SWITCH_BIT] = q.switchover_flag;
          d.rdata[BATT_LOW_BIT] = q.low_sync;
          d.rdata[BATT_SWIE_BIT] = q.switchover_irq_enable;
          d.rdata[BATT_LOWIE_BIT] = q.low_battery_irq_enable;
          // bit 4 has no function and keeps the zero default
        end
        IDX_SEC: begin
          d.rdata = {q.oscillator_stopped_flag, q.sec};
        end
        IDX_MIN: begin
          d.rdata = {1'b0, q.min};
        end
        IDX_HRS: begin
          d.rdata = {2'h0, q.hrs};
        end
        IDX_IRQ_STAT: begin
          d.rdata[2:0] = q.irq_stat;
        end
        IDX_IRQ_MASK: begin
          d.rdata[2:0] = q.irq_mask;
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // one level line: battery flags through their enables, status via mask
    // battery low is taken from the second synchroniser stage only
    d.irq = (d.switchover_flag & d.switchover_irq_enable)
      | (q.low_sync & d.low_battery_irq_enable)
      | (|(d.irq_stat & d.irq_mask));
  end

  // ==========================================================
  // state register
  // asynchronous reset loads the constant reset image only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  // upper read data bits are tied low: each register is one byte
  assign prdata = {24'h000000, q.rdata};
  assign pready = q.ready;
  assign pslverr = q.err;
  assign irq = q.irq;

endmodule // rtc3_top

// file: rtc3_pkg.sv
/*
  rtc3_pkg: register indices, field positions, reset values and timing
  counts for the battery control and timekeeping block.
  Assumes a 50 MHz pclk and an APB master with 32-bit data.
*/
// Operation
// - three-bit battery power mode in bits 7:5, reset value all ones
// - switchover flag in bit 3 sets on a switchover, zero after reset
// - switchover flag drives interrupt only while its enable bit 1 is one
// - low battery flag drives interrupt only while its enable bit 0 is one
// - time registers hold BCD, tens digit high, units digit low
// - seconds 0 to 59 as BCD in bits 6:0
// - oscillator stopped flag in seconds bit 7, one at startup and after a stop
// - seconds tens digit in bits 6:4, units in bits 3:0
// - 12 hour mode: hour 1 to 12 in bits 4:0, bit 5 PM
// - 24 hour mode: hour 0 to 23 in bits 5:0, bits 7:6 unused
// - hour layout chosen by the hour format bit of the format register
// - hour format bit zero means 24 hour mode, its reset value
package rtc3_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_HOUR_FMT = 8'h00;
  localparam logic [7:0] IDX_BATT = 8'h02;
  localparam logic [7:0] IDX_SEC = 8'h03;
  localparam logic [7:0] IDX_MIN = 8'h04;
  localparam logic [7:0] IDX_HRS = 8'h05;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

  // ==========================================================
  // field positions
  localparam int FMT_12H_BIT = 3;
  localparam int BATT_MODE_LSB = 5;
  localparam int BATT_SWITCH_BIT = 3;
  localparam int BATT_LOW_BIT = 2;
  localparam int BATT_SWIE_BIT = 1;
  localparam int BATT_LOWIE_BIT = 0;
  localparam int SEC_OSC_BIT = 7;
  localparam int HRS_PM_BIT = 5;
  localparam int IRQ_SECOND_BIT = 0;
  localparam int IRQ_MINUTE_BIT = 1;
  localparam int IRQ_OSC_BIT = 2;

  // ==========================================================
  // reset values
  localparam logic [2:0] BATT_MODE_RESET = 3'h7;
  localparam logic [6:0] SEC_RESET = 7'h00;
  localparam logic [6:0] MIN_RESET = 7'h00;
  localparam logic [5:0] HRS_RESET = 6'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ==========================================================
  // BCD limits and timing
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam longint CLK_HZ = 50_000_000;
  localparam longint TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES = int'((CLK_HZ * TICK_PERIOD_MS) / 1000);
  localparam int TICK_W = 26;

endpackage

// file: rtc3_bcd_inc.sv
/*
  rtc3_bcd_inc: combinational two-digit BCD step with wrap.
  Assumes the caller holds a legal BCD value; illegal codes still step.
*/
`timescale 1ns/1ps
module rtc3_bcd_inc (
  // value and limits
  input wire logic [7:0] cur,
  input wire logic [7:0] top_val,
  input wire logic [7:0] low_val,
  // result
  output logic [7:0] nxt,
  output logic wrap
);

  // step units, carry into tens at nine, wrap at the top value
  always_comb begin
    wrap = 1'b0;
    if (cur >= top_val) begin
      nxt = low_val;
      wrap = 1'b1;
    end else if (cur[3:0] >= 4'h9) begin
      nxt = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {cur[7:4], cur[3:0] + 4'h1};
    end
  end

endmodule // rtc3_bcd_inc

// file: rtc3_tick_gen.sv
/*
  rtc3_tick_gen: one-second prescaler giving a one-cycle tick.
  Assumes pclk is the only clock; period comes from the top parameter.
*/
`timescale 1ns/1ps
module rtc3_tick_gen
  import rtc3_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic [rtc3_pkg::TICK_W-1:0] period,
  // tick out
  output logic tick
);

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } rtc3_tick_s;

  rtc3_tick_s q, d;

  // count down to one, then reload; restart realigns the second
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (restart) begin
      d.cnt = period;
    end else if (q.cnt <= TICK_W'(1)) begin
      d.cnt = period;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - TICK_W'(1);
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule // rtc3_tick_gen

// file: rtc3_monitor.sv
/*
  rtc3_monitor: port assertions for rtc3_top.
  Assumes it is bound into rtc3_top and sees only its ports.
*/
`timescale 1ns/1ps
module rtc3_monitor
  import rtc3_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic switchover_in,
  input wire logic irq
);
  logic [7:0] idx;
  logic mapped;
  logic rd_ok;
  logic sw_en_q;
  logic sw_en_d;
  assign idx = paddr[9:2];
  assign mapped = paddr[11:10] == 2'h0 && idx inside {IDX_HOUR_FMT, IDX_BATT, IDX_SEC,
    IDX_MIN, IDX_HRS, IDX_IRQ_STAT, IDX_IRQ_MASK};
  assign rd_ok = pready && !pwrite && !pslverr;
  // shadow of the switchover enable, taken at the access edge
  always_comb begin
    sw_en_d = sw_en_q;
    if (psel && penable && pready && pwrite && pstrb[0] && idx == IDX_BATT) begin
      sw_en_d = pwdata[1];
    end
  end
  // registered shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_en_q <= 1'b0;
    end else begin
      sw_en_q <= sw_en_d;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_batt_bit_unused: assert property (rd_ok && idx == IDX_BATT |-> !prdata[4])
    else $error("unused battery bit set");
  a_sec_bcd_range: assert property (rd_ok && idx == IDX_SEC |->
    prdata[3:0] <= 4'h9 && prdata[6:4] <= 3'h5)
    else $error("seconds not bcd");
  a_min_bcd_range: assert property (rd_ok && idx == IDX_MIN |->
    prdata[7:0] <= 8'h59 && prdata[3:0] <= 4'h9)
    else $error("minutes not bcd");
  a_hours_top_zero: assert property (rd_ok && idx == IDX_HRS |-> prdata[7:6] == 2'h0)
    else $error("hours unused bits set");
  a_switch_irq_rise: assert property (sw_en_q && $rose(switchover_in) |-> ##[1:6] irq)
    else $error("switchover irq missing");
endmodule // rtc3_monitor

bind rtc3_top rtc3_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .switchover_in(switchover_in),
  .irq(irq));

// file: rtc3_host.sv
/*
  rtc3_host: apb master model standing in for the host processor.
  Assumes one transfer at a time, started through task xfer.
*/
`timescale 1ns/1ps
module rtc3_host (
  // clock
  input wire logic pclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // one transfer; released data is inverted so stale values never match
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule // rtc3_host

// file: test_rtc_control3_and_time_regs.sv
/*
  test_rtc_control3_and_time_regs: self-checking bench for rtc3_top.
  Assumes rtc3_host as apb master and a shortened one-second count.
*/
`timescale 1ns/1ps
module test_rtc_control3_and_time_regs;
  import rtc3_pkg::*;
  localparam int TICKS = 200;
  // fmt, hours in, hours expected after carry
  localparam logic [23:0] HCASE [5] = '{24'h002300, 24'h000910, 24'h081132,
    24'h083221, 24'h083112};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic sw_in, low_in, osc_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int n_mismatch, checks_done, seed, i, s;

  rtc3_top #(.TICK_CYCLES(TICKS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .switchover_in(sw_in),
    .battery_low_in(low_in), .osc_fail_in(osc_in), .irq(irq));
  rtc3_host HOST (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ==========================================================
  // helpers
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    HOST.xfer(1'b1, idx, d, rd, err);
  endtask
  task automatic rdx(input logic [7:0] idx, input logic [31:0] exp,
    input logic [31:0] msk = 32'hFFFF_FFFF);
    HOST.xfer(1'b0, idx, 8'h00, rd, err);
    chk(rd & msk, exp);
  endtask
  task automatic wait_tick();
    repeat (TICKS + 5) @(posedge pclk);
  endtask
  // pins pass a two-stage synchroniser before taking effect
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // watchdog
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 50;
    n_mismatch = 0;
    checks_done = 0;
    presetn = 1'b0;
    sw_in = 1'b0;
    low_in = 1'b0;
    osc_in = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdx(IDX_BATT, 32'hE0);
    rdx(IDX_SEC, 32'h80, 32'h80);
    rdx(IDX_HOUR_FMT, 32'h0);
    for (i = 0; i < 5; i++) begin
      wr(IDX_HOUR_FMT, HCASE[i][23:16]);
      wr(IDX_HRS, HCASE[i][15:8]);
      wr(IDX_MIN, 8'h59);
      wr(IDX_SEC, 8'h59);
      wait_tick();
      rdx(IDX_SEC, 32'h0);
      rdx(IDX_MIN, 32'h0);
      rdx(IDX_HRS, {24'h0, HCASE[i][7:0]});
    end
    // every case wrapped the seconds, so second and minute status stand
    rdx(IDX_IRQ_STAT, 32'h3, 32'h3);
    for (i = 0; i < 4; i++) begin
      s = $unsigned($random(seed)) % 59;
      wr(IDX_SEC, bcd(s));
      wait_tick();
      rdx(IDX_SEC, {24'h0, bcd(s + 1)});
    end
    wr(IDX_BATT, 8'hA3);
    rdx(IDX_BATT, 32'hA3);
    chk(irq, 1'b0);
    low_in <= 1'b1;
    settle();
    chk(irq, 1'b1);
    rdx(IDX_BATT, 32'hA7);
    wr(IDX_BATT, 8'hA2);
    settle();
    chk(irq, 1'b0);
    low_in <= 1'b0;
    sw_in <= 1'b1;
    settle();
    chk(irq, 1'b1);
    rdx(IDX_BATT, 32'hAA);
    wr(IDX_BATT, 8'hA0);
    settle();
    chk(irq, 1'b0);
    sw_in <= 1'b0;
    settle();
    sw_in <= 1'b1;
    settle();
    rdx(IDX_BATT, 32'hA8);
    chk(irq, 1'b0);
    wr(IDX_BATT, 8'h00);
    HOST.xfer(1'b0, 8'h10, 8'h00, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    rdx(IDX_IRQ_STAT, 32'h1, 32'h1);
    wr(IDX_IRQ_MASK, 8'h01);
    rdx(IDX_IRQ_MASK, 32'h1);
    wr(IDX_SEC, 8'h00);
    chk(irq, 1'b0);
    wait_tick();
    chk(irq, 1'b1);
    rdx(IDX_IRQ_STAT, 32'h1, 32'h1);
    wr(IDX_IRQ_MASK, 8'h04);
    settle();
    chk(irq, 1'b0);
    osc_in <= 1'b1;
    settle();
    chk(irq, 1'b1);
    rdx(IDX_SEC, 32'h80, 32'h80);
    rdx(IDX_IRQ_STAT, 32'h4, 32'h4);
    settle();
    chk(irq, 1'b0);
    complete_run();
  end
endmodule // test_rtc_control3_and_time_regs
